// file: rtl/spi_ctrl_pkg.sv
// Constants and types shared by the SPI controller and its testbench
package spi_ctrl_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_PIN_CFG = 8'h00;
    localparam logic [7:0] ADDR_FMT = 8'h04;
    localparam logic [7:0] ADDR_TX1 = 8'h08;
    localparam logic [7:0] ADDR_TX2 = 8'h0C;
    localparam logic [7:0] ADDR_TX3 = 8'h10;
    localparam logic [7:0] ADDR_RX1 = 8'h14;
    localparam logic [7:0] ADDR_RX2 = 8'h18;
    localparam logic [7:0] ADDR_RX3 = 8'h1C;
    localparam logic [7:0] ADDR_EXE = 8'h20;
    localparam logic [7:0] ADDR_DIAG = 8'h24;
    localparam logic [7:0] ADDR_STAT = 8'h28;
    // Field positions
    localparam int PIN_EN_BIT = 0;
    localparam int FMT_CPHA_BIT = 5;
    localparam int FMT_CPOL_BIT = 6;
    localparam int EXE_GO_BIT = 0;
    localparam int EXE_SEL_BIT = 1;
    localparam int DIAG_LOOP_BIT = 0;
    // Reset values
    localparam logic [7:0] FMT_RST = 8'h18;
    localparam logic SEL_RST = 1'b1;
    // Transfer sizes
    localparam int MAX_BITS = 24;
    localparam int WORD_W = 24;
    localparam int FIFO_DEPTH = 8;
    // Serial clock timing
    localparam int CLK_NS = 8;
    localparam int SCLK_HALF_NS = 40;
    localparam int HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Shift engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETUP = 2'b01,
        ST_HIGH = 2'b10
    } spi_state_e;
endpackage

// file: rtl/spi_rx_fifo.sv
// Receive word FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module spi_rx_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= AW'(wr_ptr + 1'b1);
            end
            if (pop)
            begin
                rd_ptr <= AW'(rd_ptr + 1'b1);
            end
            if (push && !pop)
            begin
                count <= (AW+1)'(count + 1'b1);
            end
            else if (pop && !push)
            begin
                count <= (AW+1)'(count - 1'b1);
            end
        end
    end
endmodule
`default_nettype wire

// file: rtl/spi_controller_with_loopback.sv
// SPI controller with internal loopback behind an AXI4-Lite register slave
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module spi_controller_with_loopback (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // AXI4-Lite write channels
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Serial pins
    output logic general_pin_four_out,
    output logic general_pin_four_oe_b,
    output logic general_pin_five_out,
    output logic general_pin_five_oe_b,
    input wire logic general_pin_six_in,
    output logic general_pin_seven_out,
    output logic general_pin_seven_oe_b
);
    // ********************************
    // Registers and bus slave
    // ********************************
    localparam int WORD_W = spi_ctrl_pkg::WORD_W;
    logic spi_en;
    logic [7:0] fmt;
    logic [7:0] tx1;
    logic [7:0] tx2;
    logic [7:0] tx3;
    logic go;
    logic sel_ctrl;
    logic loopback;
    logic aw_hold;
    logic w_hold;
    logic [7:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_lane0;
    spi_ctrl_pkg::spi_state_e state;
    logic [WORD_W-1:0] rx_word;
    logic rx_valid;
    logic rx_ready;
    logic rx_pop;

    wire wr_fire = aw_hold && w_hold;
    wire wr_en = wr_fire && w_lane0;
    wire hit_exe = (aw_addr_q == spi_ctrl_pkg::ADDR_EXE);
    wire wr_exe = wr_en && hit_exe;
    wire cpha = fmt[spi_ctrl_pkg::FMT_CPHA_BIT];
    wire cpol = fmt[spi_ctrl_pkg::FMT_CPOL_BIT];
    wire idle = (state == spi_ctrl_pkg::ST_IDLE);
    wire ar_fire = arvalid && arready;
    wire wr_known = (aw_addr_q <= spi_ctrl_pkg::ADDR_STAT)
        && (aw_addr_q[1:0] == 2'b00);
    wire rd_known = (araddr <= spi_ctrl_pkg::ADDR_STAT)
        && (araddr[1:0] == 2'b00);
    wire [7:0] stat = {5'h0, !rx_ready, rx_valid, go};
    wire [7:0] exe_rd = {6'h0, sel_ctrl, go};
    // Receive bytes show the oldest finished word
    wire [7:0] rd_byte =
        (araddr == spi_ctrl_pkg::ADDR_PIN_CFG) ? {7'h0, spi_en} :
        (araddr == spi_ctrl_pkg::ADDR_FMT) ? fmt :
        (araddr == spi_ctrl_pkg::ADDR_TX1) ? tx1 :
        (araddr == spi_ctrl_pkg::ADDR_TX2) ? tx2 :
        (araddr == spi_ctrl_pkg::ADDR_TX3) ? tx3 :
        (araddr == spi_ctrl_pkg::ADDR_RX1) ? rx_word[7:0] :
        (araddr == spi_ctrl_pkg::ADDR_RX2) ? rx_word[15:8] :
        (araddr == spi_ctrl_pkg::ADDR_RX3) ? rx_word[23:16] :
        (araddr == spi_ctrl_pkg::ADDR_EXE) ? exe_rd :
        (araddr == spi_ctrl_pkg::ADDR_DIAG) ? {7'h0, loopback} :
        (araddr == spi_ctrl_pkg::ADDR_STAT) ? stat : 8'h00;

    assign awready = !aw_hold && !bvalid;
    assign wready = !w_hold && !bvalid;
    assign arready = !rvalid;
    // Reading the top receive byte frees the word
    assign rx_pop = ar_fire && rx_valid
        && (araddr == spi_ctrl_pkg::ADDR_RX3);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 8'h00;
            w_lane0 <= 1'b0;
            bvalid <= 1'b0;
            bresp <= spi_ctrl_pkg::RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_hold <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_hold <= 1'b1;
                w_data_q <= wdata[7:0];
                w_lane0 <= wstrb[0];
            end
            if (wr_fire)
            begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_known ? spi_ctrl_pkg::RESP_OKAY
                    : spi_ctrl_pkg::RESP_SLVERR;
            end
            else if (bvalid && bready)
            begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= spi_ctrl_pkg::RESP_OKAY;
        end
        else if (ar_fire)
        begin
            rvalid <= 1'b1;
            rdata <= {24'h00_0000, rd_byte};
            rresp <= rd_known ? spi_ctrl_pkg::RESP_OKAY
                : spi_ctrl_pkg::RESP_SLVERR;
        end
        else if (rready)
        begin
            rvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            spi_en <= 1'b0;
            fmt <= spi_ctrl_pkg::FMT_RST;
            tx1 <= 8'h00;
            tx2 <= 8'h00;
            tx3 <= 8'h00;
            loopback <= 1'b0;
        end
        else if (wr_en)
        begin
            case (aw_addr_q)
                spi_ctrl_pkg::ADDR_PIN_CFG:
                    spi_en <= w_data_q[spi_ctrl_pkg::PIN_EN_BIT];
                spi_ctrl_pkg::ADDR_FMT: fmt <= w_data_q;
                spi_ctrl_pkg::ADDR_TX1: tx1 <= w_data_q;
                spi_ctrl_pkg::ADDR_TX2: tx2 <= w_data_q;
                spi_ctrl_pkg::ADDR_TX3: tx3 <= w_data_q;
                spi_ctrl_pkg::ADDR_DIAG:
                    loopback <= w_data_q[spi_ctrl_pkg::DIAG_LOOP_BIT];
                default: ;
            endcase
        end
    end

    // ********************************
    // Shift engine
    // ********************************
    logic [2:0] div_cnt;
    logic [4:0] bit_left;
    logic [WORD_W-1:0] shreg;
    logic [WORD_W-1:0] rx_sh;
    logic mosi_q;
    logic miso_m;
    logic miso_s;

    wire [4:0] num = fmt[4:0];
    wire [4:0] eff = (num == 5'd0) ? 5'd1 :
        (num > 5'(spi_ctrl_pkg::MAX_BITS)) ?
        5'(spi_ctrl_pkg::MAX_BITS) : num;
    wire [WORD_W-1:0] tx_word = {tx3, tx2, tx1};
    wire [WORD_W-1:0] load = tx_word << (5'd24 - eff);
    wire start = go && idle && rx_ready;
    wire tick = !idle
        && (div_cnt == 3'(spi_ctrl_pkg::HALF_CYC - 1));
    wire lead = tick && (state == spi_ctrl_pkg::ST_SETUP);
    wire trail = tick && (state == spi_ctrl_pkg::ST_HIGH);
    wire sample = cpha ? trail : lead;
    wire shift_out = cpha ? lead : trail;
    wire done = trail && (bit_left == 5'd1);
    wire din = loopback ? mosi_q : miso_s;
    wire [WORD_W-1:0] rx_next = cpha ? {rx_sh[22:0], din} : rx_sh;
    wire sclk_int = cpol ^ (state == spi_ctrl_pkg::ST_HIGH);

    // MISO synchroniser
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            miso_m <= 1'b0;
            miso_s <= 1'b0;
        end
        else
        begin
            miso_m <= general_pin_six_in;
            miso_s <= miso_m;
        end
    end

    // Execute register: go and select
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            go <= 1'b0;
            sel_ctrl <= spi_ctrl_pkg::SEL_RST;
        end
        else
        begin
            if (wr_exe)
            begin
                sel_ctrl <= w_data_q[spi_ctrl_pkg::EXE_SEL_BIT];
            end
            if (done)
            begin
                go <= 1'b0;
            end
            else if (wr_exe && w_data_q[spi_ctrl_pkg::EXE_GO_BIT])
            begin
                go <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_cnt <= 3'd0;
        end
        else if (idle || tick)
        begin
            div_cnt <= 3'd0;
        end
        else
        begin
            div_cnt <= 3'(div_cnt + 1'b1);
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= spi_ctrl_pkg::ST_IDLE;
            bit_left <= 5'd0;
            shreg <= '0;
            rx_sh <= '0;
            mosi_q <= 1'b0;
        end
        else if (start)
        begin
            state <= spi_ctrl_pkg::ST_SETUP;
            bit_left <= eff;
            shreg <= cpha ? load : {load[22:0], 1'b0};
            rx_sh <= '0;
            mosi_q <= cpha ? mosi_q : load[23];
        end
        else
        begin
            case (state)
                spi_ctrl_pkg::ST_SETUP:
                    if (tick)
                    begin
                        state <= spi_ctrl_pkg::ST_HIGH;
                    end
                spi_ctrl_pkg::ST_HIGH:
                    if (tick)
                    begin
                        state <= done ? spi_ctrl_pkg::ST_IDLE
                            : spi_ctrl_pkg::ST_SETUP;
                        bit_left <= 5'(bit_left - 1'b1);
                    end
                default: state <= spi_ctrl_pkg::ST_IDLE;
            endcase
            if (shift_out)
            begin
                mosi_q <= shreg[23];
                shreg <= {shreg[22:0], 1'b0};
            end
            if (sample)
            begin
                rx_sh <= {rx_sh[22:0], din};
            end
        end
    end

    spi_rx_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(spi_ctrl_pkg::FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(done),
        .in_ready(rx_ready),
        .in_data(rx_next),
        .out_valid(rx_valid),
        .out_ready(rx_pop),
        .out_data(rx_word)
    );

    // ********************************
    // Pin drivers
    // ********************************
    logic pin_sclk;
    logic pin_mosi;
    logic pin_ss;

    // Frozen while loopback runs
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_sclk <= 1'b0;
            pin_mosi <= 1'b0;
            pin_ss <= spi_ctrl_pkg::SEL_RST;
        end
        else if (!loopback)
        begin
            pin_sclk <= sclk_int;
            pin_mosi <= mosi_q;
            pin_ss <= sel_ctrl;
        end
    end

    assign general_pin_four_out = pin_sclk;
    assign general_pin_five_out = pin_mosi;
    assign general_pin_seven_out = pin_ss;
    assign general_pin_four_oe_b = !spi_en;
    assign general_pin_five_oe_b = !spi_en;
    assign general_pin_seven_oe_b = !spi_en;

    // ********************************
    // Assertions
    // ********************************
    logic [4:0] smp_cnt;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            smp_cnt <= 5'd0;
        end
        else if (start)
        begin
            smp_cnt <= 5'd0;
        end
        else if (sample)
        begin
            smp_cnt <= 5'(smp_cnt + 1'b1);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    property p_pin_hand;
        $rose(spi_en) |-> !general_pin_four_oe_b && !general_pin_seven_oe_b;
    endproperty
    a_pin_hand: assert property (p_pin_hand)
        else $error("pins not handed over on enable");
    property p_idle_clk;
        idle && $past(idle) && $stable(cpol) && !$past(loopback)
            |-> general_pin_four_out == cpol;
    endproperty
    a_idle_clk: assert property (p_idle_clk)
        else $error("serial clock not at idle level");
    property p_start_sel;
        wr_exe && w_data_q[1:0] == 2'b01 && !go |=> go && !sel_ctrl;
    endproperty
    a_start_sel: assert property (p_start_sel)
        else $error("execute one did not start with select low");
    property p_deselect;
        wr_exe && w_data_q[1:0] == 2'b10 && idle |=> sel_ctrl && !go;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("execute two misbehaved");
    property p_loop_static;
        loopback && $past(loopback) |-> $stable(general_pin_four_out)
            && $stable(general_pin_five_out) && $stable(pin_ss);
    endproperty
    a_loop_static: assert property (p_loop_static)
        else $error("pin moved during loopback");
    property p_loop_ss;
        $rose(loopback) |-> pin_ss == $past(sel_ctrl);
    endproperty
    a_loop_ss: assert property (p_loop_ss)
        else $error("select not latched on loopback entry");
    property p_bit_count;
        $fell(go) |-> smp_cnt == $past(eff);
    endproperty
    a_bit_count: assert property (p_bit_count)
        else $error("wrong number of bits shifted");
    property p_go_clear;
        done |=> !go && idle;
    endproperty
    a_go_clear: assert property (p_go_clear)
        else $error("go did not clear at completion");
    property p_edge_sel;
        sample |-> (cpha ? state == spi_ctrl_pkg::ST_HIGH
            : state == spi_ctrl_pkg::ST_SETUP);
    endproperty
    a_edge_sel: assert property (p_edge_sel)
        else $error("sampled on wrong edge");
    property p_loop_data;
        done && loopback && eff == 5'd24 |-> rx_next == tx_word;
    endproperty
    a_loop_data: assert property (p_loop_data)
        else $error("loopback data mismatch");
    property p_busy_hold;
        go && !idle && !done && wr_exe |=> go;
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy transfer disturbed");

    c_loop: cover property (done && loopback);
    c_cpha1: cover property (done && cpha && cpol);
    c_full: cover property (go && idle && !rx_ready);
endmodule
`default_nettype wire

// file: tb/spi_peripheral_model.sv
// Behavioural SPI peripheral on the far side of the serial pins
`timescale 1ns/1ps
`default_nettype none
module spi_peripheral_model (
    // Serial pins
    input wire logic sclk,
    input wire logic mosi,
    input wire logic ss_b,
    output logic miso,
    // Format and data
    input wire logic cpol,
    input wire logic cpha,
    input wire logic [4:0] nbits,
    input wire logic [23:0] reply,
    output logic [23:0] heard
);
    // ****************************************
    // Shift behaviour
    // ****************************************
    int idx;
    initial miso = 1'b0;
    initial heard = '0;
    // Selected: capture cleared, first bit out unless cpha is set
    always @(negedge ss_b)
    begin
        idx = int'(nbits) - 1;
        heard = '0;
        if (!cpha)
            miso = reply[idx];
    end
    // Released line shows the inverse of its last level
    always @(posedge ss_b)
        miso = ~miso;
    // Leading edge leaves the idle level
    always @(sclk)
        if (!ss_b && sclk !== cpol)
        begin
            if (cpha)
                miso = reply[idx];
            else
                heard = {heard[22:0], mosi};
        end
        else if (!ss_b)
        begin
            if (cpha)
                heard = {heard[22:0], mosi};
            idx = idx - 1;
            if (!cpha && idx >= 0)
                miso = reply[idx];
        end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the SPI controller with loopback
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, cpol, cpha;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, bseen;
    logic general_pin_four_out, general_pin_four_oe_b;
    logic general_pin_five_out, general_pin_five_oe_b, general_pin_six_in;
    logic general_pin_seven_out, general_pin_seven_oe_b;
    logic [4:0] nbits;
    logic [23:0] reply, heard;
    logic [2:0] pins_q;
    int fail_count = 0;
    int comparisons = 0;
    int edges = 0;
    int moves = 0;
    wire logic sck_w = general_pin_four_oe_b ? 1'b0 : general_pin_four_out;
    wire logic mo_w = general_pin_five_oe_b ? 1'b0 : general_pin_five_out;
    wire logic ss_w = general_pin_seven_oe_b ? 1'b1 : general_pin_seven_out;
    spi_controller_with_loopback DUT (.clk, .rst_b, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .general_pin_four_out, .general_pin_four_oe_b, .general_pin_five_out,
        .general_pin_five_oe_b, .general_pin_six_in, .general_pin_seven_out,
        .general_pin_seven_oe_b);
    spi_peripheral_model partner (.sclk(sck_w), .mosi(mo_w), .ss_b(ss_w),
        .miso(general_pin_six_in), .cpol(cpol), .cpha(cpha), .nbits(nbits),
        .reply(reply), .heard(heard));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (sck_w !== pins_q[2])
            edges++;
        if ({sck_w, mo_w, ss_w} !== pins_q)
            moves++;
        pins_q <= {sck_w, mo_w, ss_w};
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("Checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic timeout;
        fail_count++;
        $display("BAD wait expected answer seen none");
        final_report();
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        logic ad = 0;
        logic wd = 0;
        logic got = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= 32'(d);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!got)
        begin
            @(negedge clk);
            ad |= awready;
            wd |= wready;
            got = bvalid;
            bseen = bresp;
            if (++n > 100)
                timeout();
            @(posedge clk);
            if (ad)
                awvalid <= 1'b0;
            if (wd)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        int n = 0;
        logic ad = 0;
        logic got = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got)
        begin
            @(negedge clk);
            ad |= arready;
            got = rvalid;
            v = rdata;
            bseen = rresp;
            if (++n > 100)
                timeout();
            @(posedge clk);
            if (ad)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask
    task automatic wait_idle;
        logic [31:0] v;
        int n = 0;
        do
        begin
            rd(spi_ctrl_pkg::ADDR_EXE, v);
            if (++n > 400)
                timeout();
        end while (v[0] !== 1'b0);
    endtask
    task automatic wr_tx(input logic [23:0] w);
        wr(spi_ctrl_pkg::ADDR_TX1, w[7:0]);
        wr(spi_ctrl_pkg::ADDR_TX2, w[15:8]);
        wr(spi_ctrl_pkg::ADDR_TX3, w[23:16]);
    endtask
    task automatic rd_rx(output logic [23:0] w);
        logic [31:0] a, b, c;
        rd(spi_ctrl_pkg::ADDR_RX1, a);
        rd(spi_ctrl_pkg::ADDR_RX2, b);
        rd(spi_ctrl_pkg::ADDR_RX3, c);
        w = {c[7:0], b[7:0], a[7:0]};
    endtask
    task automatic t_reset;
        logic [31:0] v;
        check("oe_b", {general_pin_four_oe_b, general_pin_five_oe_b,
            general_pin_seven_oe_b}, 3'b111);
        rd(spi_ctrl_pkg::ADDR_FMT, v);
        check("format", v, 32'(spi_ctrl_pkg::FMT_RST));
        rd(spi_ctrl_pkg::ADDR_EXE, v);
        check("execute", v, 32'h0000_0002);
        rd(8'h2C, v);
        check("unmapped resp", bseen, spi_ctrl_pkg::RESP_SLVERR);
        wr(8'h2C, 8'h01);
        check("unmapped wr", bseen, spi_ctrl_pkg::RESP_SLVERR);
        wr(spi_ctrl_pkg::ADDR_PIN_CFG, 8'h01);
        check("oe_b", {general_pin_four_oe_b, general_pin_five_oe_b,
            general_pin_seven_oe_b}, 3'b000);
        $display("test reset done");
    endtask
    task automatic t_modes;
        logic [23:0] tx, m, w;
        int e0;
        for (int k = 0; k < 4; k++)
        begin
            nbits = k == 0 ? 5'd1 : k == 1 ? 5'd8 : k == 2 ? 5'd13 : 5'd24;
            {cpol, cpha} = 2'(k);
            tx = 24'h96_A5C3 + 24'(k);
            reply = ~tx;
            m = 24'((32'h1 << nbits) - 1);
            wr(spi_ctrl_pkg::ADDR_FMT, {1'b0, cpol, cpha, nbits});
            repeat (2) @(negedge clk);
            check("idle clock", sck_w, cpol);
            wr_tx(tx);
            e0 = edges;
            wr(spi_ctrl_pkg::ADDR_EXE, 8'h01);
            wr(spi_ctrl_pkg::ADDR_EXE, 8'h01);
            check("select", ss_w, 1'b0);
            wait_idle();
            repeat (20) @(posedge clk);
            check("edges", edges - e0, 2 * nbits);
            check("mosi word", heard, tx & m);
            rd_rx(w);
            check("miso word", w, reply & m);
            check("idle clock", sck_w, cpol);
            wr(spi_ctrl_pkg::ADDR_EXE, 8'h02);
            repeat (2) @(negedge clk);
            check("select", ss_w, 1'b1);
        end
        $display("test modes done");
    endtask
    task automatic t_loop;
        logic [23:0] w;
        int p0;
        wr_tx(24'hA1_B2C3);
        wr(spi_ctrl_pkg::ADDR_FMT, 8'h18);
        wr(spi_ctrl_pkg::ADDR_DIAG, 8'h01);
        p0 = moves;
        wr(spi_ctrl_pkg::ADDR_EXE, 8'h01);
        wait_idle();
        rd_rx(w);
        check("loop word", w, 24'hA1_B2C3);
        check("pin moves", moves - p0, 0);
        check("select", ss_w, 1'b1);
        $display("test loopback done");
    endtask
    task automatic t_fifo;
        logic [31:0] v;
        logic [23:0] w;
        wr(spi_ctrl_pkg::ADDR_FMT, 8'h08);
        for (int i = 0; i < 8; i++)
        begin
            wr(spi_ctrl_pkg::ADDR_TX1, 8'(i));
            wr(spi_ctrl_pkg::ADDR_EXE, 8'h01);
            wait_idle();
        end
        rd(spi_ctrl_pkg::ADDR_STAT, v);
        check("status full", v, 32'h0000_0006);
        wr(spi_ctrl_pkg::ADDR_EXE, 8'h01);
        repeat (300) @(posedge clk);
        rd(spi_ctrl_pkg::ADDR_EXE, v);
        check("stalled go", v[0], 1'b1);
        for (int i = 0; i < 9; i++)
        begin
            rd_rx(w);
            wait_idle();
            check("fifo word", w, 24'(i < 8 ? i : 7));
        end
        rd(spi_ctrl_pkg::ADDR_STAT, v);
        check("status empty", v, 32'h0000_0000);
        wr(spi_ctrl_pkg::ADDR_DIAG, 8'h00);
        wr(spi_ctrl_pkg::ADDR_EXE, 8'h02);
        wr(spi_ctrl_pkg::ADDR_PIN_CFG, 8'h00);
        check("oe_b", {general_pin_four_oe_b, general_pin_five_oe_b,
            general_pin_seven_oe_b}, 3'b111);
        $display("test fifo done");
    endtask
    initial
    begin
        rst_b = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hF;
        {cpol, cpha, nbits, reply} = '0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_modes();
        t_loop();
        t_fifo();
        final_report();
    end
endmodule
`default_nettype wire
